// ==== common/power_supervisor_pkg.sv ====
package power_supervisor_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_FREQ_KHZ         = 10000;
    localparam int SHUTDOWN_DEBOUNCE_US = 8000;
    localparam int SHUTDOWN_DEBOUNCE_CYCLES =
        SHUTDOWN_DEBOUNCE_US * (CLK_FREQ_KHZ / 1000);

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] COIN_CTRL_ADDR    = 8'h1a;
    localparam logic [7:0] BACKUP_CTRL_ADDR  = 8'h6b;
    localparam logic [7:0] SENSE_ADDR        = 8'h05;
    localparam logic [7:0] COIN_CTRL_RESET   = 8'h00;
    localparam logic [7:0] BACKUP_CTRL_RESET = 8'h00;
    localparam logic [7:0] COIN_CTRL_MASK    = 8'h0f;
    localparam logic [7:0] BACKUP_CTRL_MASK  = 8'h07;
    localparam int         CHG_ENABLE_BIT    = 3;
    localparam int         VSEL_W            = 3;
    localparam int         NUM_THERM         = 4;

    // ==========================================================
    // Charge voltage decode, in units of 10 mV
    // ==========================================================
    localparam logic [8:0] CHARGE_FIRST_CV     = 9'h0fa;
    localparam logic [8:0] CHARGE_STEP_BASE_CV = 9'h104;
    localparam logic [8:0] CHARGE_STEP_CV      = 9'h00a;

    typedef enum logic [1:0] {PM_OFF, PM_ON, PM_CELL} power_mode_t;

    function automatic logic [8:0] charge_centivolts(input logic [VSEL_W-1:0] sel);
        logic [8:0] steps;
        steps = {6'h00, sel};
        if (sel == '0)
            return CHARGE_FIRST_CV;
        return 9'(CHARGE_STEP_BASE_CV + CHARGE_STEP_CV * steps);
    endfunction

endpackage

// ==== design/sync_two_flop.sv ====
`timescale 1ns/10ps
module sync_two_flop #(
    parameter int Width = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [Width-1:0] din,
    output logic      [Width-1:0] dout
);
    typedef struct packed {
        logic [Width-1:0] first;
        logic [Width-1:0] second;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    if (Width < 1) $error("sync_two_flop needs a width of at least one");

    always_comb
    begin
        st_d        = st_q;
        st_d.first  = din;
        st_d.second = st_q.first;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign dout = st_q.second;
endmodule // sync_two_flop

// ==== design/shutdown_debounce.sv ====
`timescale 1ns/10ps
module shutdown_debounce #(
    parameter int Cycles = 80000
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic level,
    output logic      held
);
    localparam int CW = $clog2(Cycles + 1);
    localparam logic [CW-1:0] LAST = CW'(Cycles - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          held;
    } deb_t;

    deb_t st_q;
    deb_t st_d;

    if (Cycles < 1) $error("shutdown_debounce needs at least one cycle");

    // The output rises only after level stayed high for Cycles samples.
    always_comb
    begin
        st_d = st_q;
        if (!level)
        begin
            st_d.count = '0;
            st_d.held  = 1'b0;
        end
        else if (st_q.count == LAST)
            st_d.held = 1'b1;
        else
            st_d.count = st_q.count + 1'b1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign held = st_q.held;

    a_restart_low : assert property (@(posedge clk) disable iff (reset)
        !level |=> !held)
        else $error("Shutdown stayed asserted after protect condition cleared");
endmodule // shutdown_debounce

// ==== design/power_mode_supervisor.sv ====
`timescale 1ns/10ps
module power_mode_supervisor
    import power_supervisor_pkg::*;
#(
    parameter int ShutdownCycles = SHUTDOWN_DEBOUNCE_CYCLES
) (
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire logic                                vinAboveUpper,
    input  wire logic                                vinBelowLower,
    input  wire logic                                vinAboveUvdet,
    input  wire logic                                cellPresent,
    input  wire logic                                powerOnPin,
    input  wire logic [power_supervisor_pkg::NUM_THERM-1:0] thermSense,
    input  wire logic                                thermProtect,
    input  wire logic                                intRequest,
    input  wire logic [7:0]                          regAddr,
    input  wire logic [7:0]                          regWrData,
    input  wire logic                                regWrite,
    input  wire logic                                regRead,
    output logic      [7:0]                          regRdData,
    output logic                                     regAck,
    output logic                                     regRefused,
    output power_supervisor_pkg::power_mode_t        powerMode,
    output logic                                     hostResetOut,
    output logic                                     hostResetOe,
    output logic                                     interruptOut,
    output logic                                     interruptOe,
    output logic                                     railsOn,
    output logic                                     backupFromMain,
    output logic                                     backupSupplyOn,
    output logic                                     coreFromCell,
    output logic                                     backupInitialHold,
    output logic      [power_supervisor_pkg::VSEL_W-1:0] backupVoltSel,
    output logic                                     chargeEnable,
    output logic      [power_supervisor_pkg::VSEL_W-1:0] chargeVoltSel,
    output logic      [8:0]                          chargeTargetCv,
    output logic      [power_supervisor_pkg::NUM_THERM-1:0] thermWarnEvent
);
    import power_supervisor_pkg::*;

    localparam int SYNC_W = NUM_THERM + 7;

    if (ShutdownCycles < 1) $error("ShutdownCycles must be at least one");

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        power_mode_t          mode;
        logic [7:0]           coinCtrl;
        logic [7:0]           backupCtrl;
        logic [NUM_THERM-1:0] thermPrev;
        logic [NUM_THERM-1:0] warnEvt;
        logic                 thermLock;
        logic                 cellPrev;
        logic                 cellFresh;
        logic                 fromMain;
        logic                 supplyOn;
        logic                 resetLevel;
        logic                 resetOe;
        logic                 intOe;
        logic                 chargeEn;
        logic [VSEL_W-1:0]    chargeSel;
        logic [8:0]           chargeCv;
        logic [VSEL_W-1:0]    backupSel;
        logic [7:0]           rdData;
        logic                 ack;
        logic                 refused;
    } sup_state_t;

    sup_state_t st_q;
    sup_state_t st_d;

    localparam sup_state_t RESET_STATE = '{
        mode:       PM_OFF,
        coinCtrl:   COIN_CTRL_RESET,
        backupCtrl: BACKUP_CTRL_RESET,
        thermPrev:  '0,
        warnEvt:    '0,
        thermLock:  1'b0,
        cellPrev:   1'b0,
        cellFresh:  1'b0,
        fromMain:   1'b0,
        supplyOn:   1'b0,
        resetLevel: 1'b0,
        resetOe:    1'b1,
        intOe:      1'b0,
        chargeEn:   1'b0,
        chargeSel:  '0,
        chargeCv:   CHARGE_FIRST_CV,
        backupSel:  '0,
        rdData:     '0,
        ack:        1'b0,
        refused:    1'b0
    };

    // ==========================================================
    // Pin synchronisation and shutdown debounce
    // ==========================================================
    logic [SYNC_W-1:0]    syncOut;
    logic                 upperS;
    logic                 lowerS;
    logic                 uvS;
    logic                 cellS;
    logic                 pwrS;
    logic                 protS;
    logic [NUM_THERM-1:0] thermS;
    logic                 shutdownHeld;
    logic                 pinsValid;

    sync_two_flop #(
        .Width (SYNC_W)
    ) pinSync (
        .clk   (clk),
        .reset (reset),
        .din   ({1'b1, vinAboveUpper, vinBelowLower, vinAboveUvdet, cellPresent,
                 powerOnPin, thermProtect, thermSense}),
        .dout  (syncOut)
    );

    // The constant top bit marks when the synchroniser holds real pin samples after reset.
    assign {pinsValid, upperS, lowerS, uvS, cellS, pwrS, protS, thermS} = syncOut;

    shutdown_debounce #(
        .Cycles (ShutdownCycles)
    ) thermDebounce (
        .clk   (clk),
        .reset (reset),
        .level (protS),
        .held  (shutdownHeld)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    logic access;

    assign access = regWrite || regRead;

    always_comb
    begin
        st_d         = st_q;
        st_d.ack     = 1'b0;
        st_d.refused = 1'b0;
        st_d.rdData  = '0;

        // Power mode machine.
        unique case (st_q.mode)
            PM_OFF:
            begin
                if (!uvS)
                    st_d.mode = PM_CELL;
                else if (pwrS && !st_q.thermLock && !shutdownHeld)
                    st_d.mode = PM_ON;
            end
            PM_ON:
            begin
                if (!uvS)
                    st_d.mode = PM_CELL;
                else if (!pwrS || shutdownHeld)
                    st_d.mode = PM_OFF;
            end
            PM_CELL:
            begin
                if (uvS)
                    st_d.mode = PM_OFF;
            end
        endcase
        // Zeros left in the synchroniser by reset must not look like undervoltage.
        if (!pinsValid)
            st_d.mode = st_q.mode;

        // Thermal protection latch, released when the comparator drops.
        if (shutdownHeld)
            st_d.thermLock = 1'b1;
        else if (!protS)
            st_d.thermLock = 1'b0;

        // Host reset and interrupt pins, both open drain.
        st_d.resetLevel = 1'b0;
        st_d.resetOe    = (st_q.mode != PM_ON);
        st_d.intOe      = (st_q.mode == PM_ON) && intRequest;

        // Thermal warning events on any crossing.
        st_d.thermPrev = thermS;
        st_d.warnEvt   = thermS ^ st_q.thermPrev;

        // Backup domain source selection with comparator hysteresis.
        if (upperS)
            st_d.fromMain = 1'b1;
        else if (lowerS)
            st_d.fromMain = 1'b0;

        // A cell arriving with no main input starts at the initial level.
        st_d.cellPrev = cellS;
        if (cellS && !st_q.cellPrev && !uvS)
            st_d.cellFresh = 1'b1;
        else if (upperS)
            st_d.cellFresh = 1'b0;
        st_d.supplyOn = st_d.fromMain || cellS;

        if (uvS)
            st_d.backupSel = st_q.backupCtrl[VSEL_W-1:0];

        // Charger gating and target voltage.
        st_d.chargeEn  = st_q.coinCtrl[CHG_ENABLE_BIT]
                         && (st_q.mode == PM_ON) && uvS;
        st_d.chargeSel = st_q.coinCtrl[VSEL_W-1:0];
        st_d.chargeCv  = charge_centivolts(st_q.coinCtrl[VSEL_W-1:0]);

        // Register port.
        if (access && st_q.mode == PM_CELL)
            st_d.refused = 1'b1;
        else if (access)
        begin
            st_d.ack = 1'b1;
            if (regWrite && regAddr == COIN_CTRL_ADDR)
                st_d.coinCtrl = regWrData & COIN_CTRL_MASK;
            else if (regWrite && regAddr == BACKUP_CTRL_ADDR)
                st_d.backupCtrl = regWrData & BACKUP_CTRL_MASK;
            if (regRead)
            begin
                unique case (regAddr)
                    COIN_CTRL_ADDR:   st_d.rdData = st_q.coinCtrl;
                    BACKUP_CTRL_ADDR: st_d.rdData = st_q.backupCtrl;
                    SENSE_ADDR:       st_d.rdData = 8'({thermS});
                    default:          st_d.rdData = '0;
                endcase
            end
        end

        // Loss of both sources wipes the retained registers.
        if (pinsValid && !st_d.supplyOn)
        begin
            st_d.coinCtrl   = COIN_CTRL_RESET;
            st_d.backupCtrl = BACKUP_CTRL_RESET;
            st_d.cellFresh  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st_q <= RESET_STATE;
        else
            st_q <= st_d;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign regRdData         = st_q.rdData;
    assign regAck            = st_q.ack;
    assign regRefused        = st_q.refused;
    assign powerMode         = st_q.mode;
    assign hostResetOut      = st_q.resetLevel;
    assign hostResetOe       = st_q.resetOe;
    assign interruptOut      = st_q.resetLevel;
    assign interruptOe       = st_q.intOe;
    assign railsOn           = st_q.resetOe == 1'b0;
    assign backupFromMain    = st_q.fromMain;
    assign backupSupplyOn    = st_q.supplyOn;
    assign coreFromCell      = !st_q.fromMain;
    assign backupInitialHold = st_q.cellFresh;
    assign backupVoltSel     = st_q.backupSel;
    assign chargeEnable      = st_q.chargeEn;
    assign chargeVoltSel     = st_q.chargeSel;
    assign chargeTargetCv    = st_q.chargeCv;
    assign thermWarnEvent    = st_q.warnEvt;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_turn_on_ok;
        uvS && pwrS && !st_q.thermLock && !shutdownHeld;
    endsequence

    sequence s_turn_off_req;
        uvS && (!pwrS || shutdownHeld);
    endsequence

    a_cell_refuse : assert property (
        (st_q.mode == PM_CELL) && access |=> regRefused && !regAck)
        else $error("Register access answered in backup cell state");

    a_int_only_on : assert property (
        interruptOe |-> $past(st_q.mode) == PM_ON)
        else $error("Interrupt driven outside the ON state");

    a_off_reset_low : assert property (
        (st_q.mode == PM_OFF) |=> hostResetOe && !hostResetOut)
        else $error("Host reset not held low in OFF");

    a_on_entry : assert property (
        (st_q.mode == PM_OFF) ##0 s_turn_on_ok |=> (st_q.mode == PM_ON) ##1 !hostResetOe)
        else $error("Valid turn-on did not reach ON with reset released");

    a_on_turn_off : assert property (
        (st_q.mode == PM_ON) ##0 s_turn_off_req |=> st_q.mode == PM_OFF)
        else $error("Turn-off event did not move ON to OFF");

    a_on_to_cell : assert property (
        (st_q.mode == PM_ON) && !uvS |=> st_q.mode == PM_CELL)
        else $error("Undervoltage in ON did not enter backup cell");

    a_cell_stays : assert property (
        (st_q.mode == PM_CELL) && !uvS |=> st_q.mode == PM_CELL)
        else $error("Backup cell state left without main input");

    a_charge_gate : assert property (
        chargeEnable |-> $past(st_q.mode == PM_ON && uvS))
        else $error("Charger enabled outside ON or under undervoltage");

    a_therm_event : assert property (
        (thermS[0] != st_q.thermPrev[0]) |=> thermWarnEvent[0] ##1 !thermWarnEvent[0])
        else $error("Thermal crossing missed or event longer than a cycle");

    a_backup_switch : assert property (
        lowerS && !upperS |=> !backupFromMain && coreFromCell)
        else $error("Backup domain not moved to the cell below lower threshold");
endmodule // power_mode_supervisor

// ==== tb/supply_env_model.sv ====
`timescale 1ns/10ps
module supply_env_model (
    input  wire logic [1:0] supplyLevel,
    input  wire logic       powerRequest,
    input  wire logic       hostResetOut,
    input  wire logic       hostResetOe,
    input  wire logic       interruptOut,
    input  wire logic       interruptOe,
    output logic            vinAboveUpper,
    output logic            vinBelowLower,
    output logic            vinAboveUvdet,
    output logic            powerOnPin,
    output logic            hostResetWire,
    output logic            interruptWire
);
    // ==========================================================
    // Supply comparators
    // ==========================================================
    // Level 0 is below the lower threshold, 1 sits between the lower and the
    // undervoltage thresholds, 2 is above undervoltage, 3 is above the upper one.
    assign vinBelowLower = (supplyLevel == 2'h0);
    assign vinAboveUvdet = supplyLevel[1];
    assign vinAboveUpper = (supplyLevel == 2'h3);

    // ==========================================================
    // Power button and open-drain host lines
    // ==========================================================
    // A released button line reads low, which the device takes as a request to power off.
    assign powerOnPin = powerRequest;
    assign hostResetWire = hostResetOe ? hostResetOut : 1'b1;
    assign interruptWire = interruptOe ? interruptOut : 1'b1;
endmodule // supply_env_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import power_supervisor_pkg::*;
    localparam int Shut = 20;
    logic        clk, reset, cellPresent, powerRequest, thermProtect, intRequest, ack, refd;
    logic        regWrite, regRead, vinAboveUpper, vinBelowLower, vinAboveUvdet, powerOnPin;
    logic        hostResetWire, interruptWire, regAck, regRefused, hostResetOut, hostResetOe;
    logic        interruptOut, interruptOe, railsOn, backupFromMain, backupSupplyOn;
    logic        coreFromCell, backupInitialHold, chargeEnable;
    logic [1:0]  supplyLevel;
    logic [3:0]  thermSense, thermWarnEvent, seen;
    logic [2:0]  backupVoltSel, chargeVoltSel;
    logic [7:0]  regAddr, regWrData, regRdData, rd;
    logic [8:0]  chargeTargetCv;
    power_mode_t powerMode;
    int          mismatches, cmp_count;
    // Each row holds address, write data and the value read back afterwards.
    logic [23:0] rows [5] = '{24'h1aff0f, 24'h1a0505, 24'h6bff07, 24'h6b0202, 24'h335a00};

    power_mode_supervisor #(.ShutdownCycles(Shut)) u_power_mode_supervisor (
        .clk(clk), .reset(reset), .vinAboveUpper(vinAboveUpper),
        .vinBelowLower(vinBelowLower), .vinAboveUvdet(vinAboveUvdet),
        .cellPresent(cellPresent), .powerOnPin(powerOnPin), .thermSense(thermSense),
        .thermProtect(thermProtect), .intRequest(intRequest), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regAck(regAck), .regRefused(regRefused),
        .powerMode(powerMode), .hostResetOut(hostResetOut), .hostResetOe(hostResetOe),
        .interruptOut(interruptOut), .interruptOe(interruptOe), .railsOn(railsOn),
        .backupFromMain(backupFromMain), .backupSupplyOn(backupSupplyOn),
        .coreFromCell(coreFromCell), .backupInitialHold(backupInitialHold),
        .backupVoltSel(backupVoltSel), .chargeEnable(chargeEnable),
        .chargeVoltSel(chargeVoltSel), .chargeTargetCv(chargeTargetCv),
        .thermWarnEvent(thermWarnEvent)
    );

    supply_env_model u_supply_env_model (
        .supplyLevel(supplyLevel), .powerRequest(powerRequest),
        .hostResetOut(hostResetOut), .hostResetOe(hostResetOe),
        .interruptOut(interruptOut), .interruptOe(interruptOe),
        .vinAboveUpper(vinAboveUpper), .vinBelowLower(vinBelowLower),
        .vinAboveUvdet(vinAboveUvdet), .powerOnPin(powerOnPin),
        .hostResetWire(hostResetWire), .interruptWire(interruptWire)
    );

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_mode(input power_mode_t got, input power_mode_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t mode got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // The strobe is held through the sampling edge and the answer is read just after it.
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= wr;
        regRead <= ~wr;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
        rd = regRdData;
        ack = regAck;
        refd = regRefused;
    endtask

    task automatic wait_mode(input power_mode_t m);
        for (int i = 0; i < 40; i++)
        begin
            settle(1);
            if (powerMode === m)
                break;
        end
        cmp_mode(powerMode, m);
    endtask

    task automatic catch_warn(input logic [3:0] exp);
        seen = 4'h0;
        repeat (6)
        begin
            settle(1);
            seen = seen | thermWarnEvent;
        end
        cmp_val({5'h00, seen}, {5'h00, exp});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {reset, cellPresent, supplyLevel} = 4'hf;
        {powerRequest, thermProtect, intRequest, regWrite, regRead} = 5'h00;
        {thermSense, regAddr, regWrData} = 20'h00000;
        settle(3);
        cmp_val(chargeTargetCv, 9'h0fa);
        cmp_mode(powerMode, PM_OFF);
        reset <= 1'b0;
        reg_op(1'b0, 8'h1a, 8'h00);
        cmp_val({1'b0, rd}, 9'h000);
        cmp_val({8'h00, ack}, 9'h001);
        reg_op(1'b0, 8'h6b, 8'h00);
        cmp_val({1'b0, rd}, 9'h000);
        cmp_val({8'h00, hostResetWire}, 9'h000);
        cmp_val({8'h00, backupFromMain}, 9'h001);
        reg_op(1'b1, 8'h1a, 8'h08);
        settle(4);
        cmp_val({8'h00, chargeEnable}, 9'h000);
        @(posedge clk);
        powerRequest <= 1'b1;
        wait_mode(PM_ON);
        settle(2);
        cmp_val({7'h00, hostResetWire, railsOn}, 9'h003);
        cmp_val({8'h00, chargeEnable}, 9'h001);
        foreach (rows[i])
        begin
            reg_op(1'b1, rows[i][23:16], rows[i][15:8]);
            cmp_val({8'h00, ack}, 9'h001);
            reg_op(1'b0, rows[i][23:16], 8'h00);
            cmp_val({1'b0, rd}, {1'b0, rows[i][7:0]});
        end
        settle(3);
        cmp_val({6'h00, backupVoltSel}, 9'h002);
        for (int s = 0; s < 8; s++)
        begin
            reg_op(1'b1, 8'h1a, {5'h01, 3'(s)});
            settle(2);
            cmp_val(chargeTargetCv, (s == 0) ? 9'h0fa : 9'(9'h104 + 9'h00a * s));
            cmp_val({6'h00, chargeVoltSel}, 9'(s));
        end
        @(posedge clk);
        intRequest <= 1'b1;
        settle(3);
        cmp_val({8'h00, interruptWire}, 9'h000);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            thermSense[k] <= 1'b1;
            catch_warn(4'(1 << k));
            reg_op(1'b0, 8'h05, 8'h00);
            cmp_val({1'b0, rd}, 9'((1 << (k + 1)) - 1));
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            thermSense[k] <= 1'b0;
            catch_warn(4'(1 << k));
        end
        @(posedge clk);
        thermProtect <= 1'b1;
        settle(Shut - 6);
        thermProtect <= 1'b0;
        settle(4);
        thermProtect <= 1'b1;
        settle(Shut - 4);
        cmp_mode(powerMode, PM_ON);
        wait_mode(PM_OFF);
        settle(10);
        cmp_mode(powerMode, PM_OFF);
        thermProtect <= 1'b0;
        wait_mode(PM_ON);
        @(posedge clk);
        powerRequest <= 1'b0;
        wait_mode(PM_OFF);
        settle(2);
        cmp_val({7'h00, hostResetWire, railsOn}, 9'h000);
        powerRequest <= 1'b1;
        wait_mode(PM_ON);
        @(posedge clk);
        supplyLevel <= 2'h1;
        wait_mode(PM_CELL);
        settle(2);
        cmp_val({8'h00, chargeEnable}, 9'h000);
        cmp_val({7'h00, interruptWire, hostResetWire}, 9'h002);
        reg_op(1'b1, 8'h1a, 8'h00);
        cmp_val({7'h00, refd, ack}, 9'h002);
        powerRequest <= 1'b0;
        settle(4);
        powerRequest <= 1'b1;
        settle(6);
        cmp_mode(powerMode, PM_CELL);
        powerRequest <= 1'b0;
        supplyLevel <= 2'h0;
        settle(4);
        cmp_val({6'h00, backupFromMain, coreFromCell, backupSupplyOn}, 9'h003);
        cellPresent <= 1'b0;
        settle(4);
        cmp_val({8'h00, backupSupplyOn}, 9'h000);
        cmp_val({6'h00, backupVoltSel}, 9'h002);
        cellPresent <= 1'b1;
        settle(4);
        cmp_val({8'h00, backupInitialHold}, 9'h001);
        supplyLevel <= 2'h3;
        wait_mode(PM_OFF);
        settle(2);
        cmp_val({8'h00, backupInitialHold}, 9'h000);
        cmp_val({6'h00, backupVoltSel}, 9'h000);
        reg_op(1'b0, 8'h1a, 8'h00);
        cmp_val({1'b0, rd}, 9'h000);
        tally_and_finish();
    end
endmodule // tb_top
